// File: design/conv_link_if.sv
`timescale 1ns/100ps

interface conv_link_if;
    logic        conv_done;
    logic [15:0] conv_code;
    logic        run;

    modport timer
    (
        output conv_done,
        output conv_code,
        input  run
    );
    modport alarm
    (
        input  conv_done,
        input  conv_code,
        output run
    );
endinterface

// File: design/conv_timer.sv
`timescale 1ns/100ps

// Converter model: ticks once per conversion period while running
module conv_timer
#(
    parameter int unsigned PERIOD_CYCLES = 13300000
)
(
    input  wire logic   sys_clk,
    input  wire logic   rst_sync_n,
    input  wire logic [15:0] sample_code,
    conv_link_if.timer  link
);
    logic [31:0] count_r;

    // Restarts from zero whenever run drops, so first result waits a period
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            count_r <= 32'h0;
        else if (!link.run || count_r == PERIOD_CYCLES - 1)
            count_r <= 32'h0;
        else
            count_r <= count_r + 32'h1;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            link.conv_done <= 1'b0;
            link.conv_code <= 16'h0;
        end
        else
        begin
            link.conv_done <= link.run && count_r == PERIOD_CYCLES - 1;
            link.conv_code <= sample_code;
        end
    end
endmodule

// File: design/temp_alarm.sv
// Operation
// - Result is 16-bit two's complement, left-justified, low unused bits zero.
// - Result loads 8000h at reset and in every shutdown cycle.
// - Out-of-tolerance is above high or below low; count consecutive only.
// - Queue depth one, two, four or six; one after reset.
// - In-tolerance result with alarm idle clears the queue.
// - Queue clears at reset and on limit or configuration writes.
// - Any queue clear deasserts the alarm.
// - Comparator: alarm asserts after depth consecutive above-high results.
// - Comparator: alarm deasserts after depth consecutive below-low results.
// - Interrupt: alarm raised for under- as well as overtemperature.
// - Interrupt: watched fault type alternates high and low.
// - Interrupt: alarm holds until any register read, then watch flips.
// - Interrupt: queue clear deasserts alarm and watches high again.
// - Interrupt: fault raised only after depth consecutive results.
// - Shutdown stops conversions and forces result to 8000h.
// - After shutdown result reads 8000h until first new conversion.
// - Queue held in reset throughout shutdown.
// - Config bits 4:3 select depth 1, 2, 4, 6.
// - Config bit 1 selects comparator (0) or interrupt (1).
// - Config bit 2 sets alarm polarity, low-active by default.
// - Config bit 0 is shutdown, normal by default.
`timescale 1ns/100ps
`include "temp_alarm_map.svh"

module temp_alarm
    import temp_alarm_pkg::*;
#(
    parameter int unsigned CONV_CYCLES =
        `TA_CONV_TIME_MS * 1000 * `TA_CLK_MHZ
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic [15:0] sample_code,
    output logic             alarm_output
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Converter
    // ------------------------------------------------------------
    conv_link_if link ();

    logic        shutdown;
    logic [15:0] sample_mask;

    // Sample pins are asynchronous to the bus clock
    logic [15:0] sample_meta_r;
    logic [15:0] sample_sync_r;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sample_meta_r <= 16'h0;
            sample_sync_r <= 16'h0;
        end
        else
        begin
            sample_meta_r <= sample_code;
            sample_sync_r <= sample_meta_r;
        end
    end

    assign link.run = !shutdown;

    conv_timer #(.PERIOD_CYCLES(CONV_CYCLES)) u_timer
    (
        .sys_clk     (sys_clk),
        .rst_sync_n  (rst_sync_n),
        .sample_code (sample_sync_r),
        .link        (link)
    );

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]  config_r;
    logic [15:0] high_r;
    logic [15:0] low_r;
    logic [15:0] temp_r;
    logic        wr_hit;
    logic        rd_any;
    logic        cfg_wr;
    logic        high_wr;
    logic        low_wr;
    logic        mapped;
    logic        rd_valid_r;

    // One wait state on reads so the registered data stands when taken
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rd_valid_r <= 1'b0;
        else
            rd_valid_r <= avs_read && !rd_valid_r;
    end

    assign avs_waitrequest = avs_read && !rd_valid_r;
    assign mapped  = avs_address[1:0] == 2'b00;
    assign wr_hit  = avs_write && mapped && avs_byteenable[0];
    assign cfg_wr  = wr_hit && avs_address == `TA_OFF_CONFIG;
    assign high_wr = wr_hit && avs_address == `TA_OFF_HIGH_LIMIT;
    assign low_wr  = wr_hit && avs_address == `TA_OFF_LOW_LIMIT;
    assign rd_any  = avs_read && mapped && !avs_waitrequest;
    assign shutdown = config_r[`TA_CFG_SHUTDOWN];

    // Limits keep only their nine significant bits
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            config_r <= `TA_RST_CONFIG;
            high_r   <= `TA_RST_HIGH_LIMIT;
            low_r    <= `TA_RST_LOW_LIMIT;
        end
        else
        begin
            if (cfg_wr)
                config_r <= avs_writedata[7:0] & `TA_CFG_MASK;
            if (high_wr && avs_byteenable[1])
                high_r <= avs_writedata[15:0] & `TA_LIMIT_MASK;
            if (low_wr && avs_byteenable[1])
                low_r <= avs_writedata[15:0] & `TA_LIMIT_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            avs_readdata <= 32'h0;
            avs_response <= 2'b00;
        end
        else if (avs_read)
        begin
            avs_response <= mapped ? 2'b00 : 2'b10;
            case (avs_address)
                `TA_OFF_TEMP:       avs_readdata <= {16'h0, temp_r};
                `TA_OFF_CONFIG:     avs_readdata <= {24'h0, config_r};
                `TA_OFF_LOW_LIMIT:  avs_readdata <= {16'h0, low_r};
                `TA_OFF_HIGH_LIMIT: avs_readdata <= {16'h0, high_r};
                default:            avs_readdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Temperature result
    // ------------------------------------------------------------
    // Width parameter of the converter: low bits below resolution read 0
    localparam int unsigned RES_BITS = 12;
    assign sample_mask = 16'hffff << (16 - RES_BITS);

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            temp_r <= `TA_NO_RESULT;
        else if (shutdown)
            temp_r <= `TA_NO_RESULT;
        else if (link.conv_done)
            temp_r <= link.conv_code & sample_mask;
    end

    // ------------------------------------------------------------
    // Fault queue and alarm
    // ------------------------------------------------------------
    logic [2:0]      depth;
    logic [2:0]      count_r;
    logic            active_r;
    watch_type       watch_r;
    alarm_mode_type  mode;
    logic            above;
    logic            below;
    logic            clear_q;
    logic            hit;
    logic            full;
    logic [15:0]     code_lim;

    always_comb
    begin
        case (config_r[`TA_CFG_DEPTH_HI:`TA_CFG_DEPTH_LO])
            2'b00:   depth = `TA_DEPTH_1;
            2'b01:   depth = `TA_DEPTH_2;
            2'b10:   depth = `TA_DEPTH_4;
            2'b11:   depth = `TA_DEPTH_6;
            default: depth = `TA_DEPTH_1;
        endcase
    end

    assign mode = config_r[`TA_CFG_MODE] ? MODE_INTERRUPT
                                         : MODE_COMPARATOR;
    assign code_lim = link.conv_code & `TA_LIMIT_MASK;
    assign above = $signed(code_lim) > $signed(high_r);
    assign below = $signed(code_lim) < $signed(low_r);
    assign clear_q = shutdown || cfg_wr || high_wr || low_wr;

    // Which condition counts toward the next alarm change
    always_comb
    begin
        if (mode == MODE_COMPARATOR)
            hit = active_r ? below : above;
        else
            hit = (watch_r == WATCH_HIGH) ? above : below;
    end

    assign full = count_r + 3'h1 >= depth;

    // Interrupt alarm is frozen until read, so the queue idles meanwhile
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            count_r <= 3'h0;
        else if (clear_q)
            count_r <= 3'h0;
        else if (link.conv_done)
        begin
            if (mode == MODE_INTERRUPT && active_r)
                count_r <= 3'h0;
            else if (!hit || full)
                count_r <= 3'h0;
            else
                count_r <= count_r + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            active_r <= 1'b0;
            watch_r  <= WATCH_HIGH;
        end
        else if (clear_q)
        begin
            active_r <= 1'b0;
            watch_r  <= WATCH_HIGH;
        end
        else if (mode == MODE_INTERRUPT)
        begin
            // Read wins: a conversion on the read cycle is not counted
            if (link.conv_done && !active_r && hit && full)
                active_r <= 1'b1;
            else if (active_r && rd_any)
            begin
                active_r <= 1'b0;
                watch_r  <= (watch_r == WATCH_HIGH) ? WATCH_LOW
                                                    : WATCH_HIGH;
            end
        end
        else if (link.conv_done && hit && full)
            active_r <= !active_r;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            alarm_output <= 1'b1;
        else
            alarm_output <= active_r ~^ config_r[`TA_CFG_POLARITY];
    end
endmodule

// File: design/temp_alarm_map.svh
`ifndef TEMP_ALARM_MAP_SVH
`define TEMP_ALARM_MAP_SVH

// Register byte offsets on the Avalon-MM word bus
`define TA_OFF_TEMP        4'h0
`define TA_OFF_CONFIG      4'h4
`define TA_OFF_LOW_LIMIT   4'h8
`define TA_OFF_HIGH_LIMIT  4'hc
`define TA_OFF_SAMPLE      4'h0

// Configuration fields
`define TA_CFG_SHUTDOWN    0
`define TA_CFG_MODE        1
`define TA_CFG_POLARITY    2
`define TA_CFG_DEPTH_LO    3
`define TA_CFG_DEPTH_HI    4
`define TA_CFG_MASK        8'h1f

// Reset values and limit mask
`define TA_RST_CONFIG      8'h00
`define TA_RST_HIGH_LIMIT  16'h5000
`define TA_RST_LOW_LIMIT   16'h4b00
`define TA_NO_RESULT       16'h8000
`define TA_LIMIT_MASK      16'hff80

// Queue depths
`define TA_DEPTH_1         3'h1
`define TA_DEPTH_2         3'h2
`define TA_DEPTH_4         3'h4
`define TA_DEPTH_6         3'h6

// Conversion period
`define TA_CONV_TIME_MS    133
`define TA_CLK_MHZ         100

`endif

// File: design/temp_alarm_pkg.sv
package temp_alarm_pkg;

    typedef enum logic [1:0]
    {
        WATCH_HIGH = 2'b01,
        WATCH_LOW  = 2'b10
    } watch_type;

    typedef enum logic [1:0]
    {
        MODE_COMPARATOR = 2'b01,
        MODE_INTERRUPT  = 2'b10
    } alarm_mode_type;

endpackage

// File: tb/sensor_source.sv
`timescale 1ns/100ps
// ----------------------------------------
// Die temperature source
// ----------------------------------------
// Registered so the code never moves on the strobe's own edge
module sensor_source
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] temp_set,
    output logic      [15:0] sample_code
);
    initial sample_code = 16'h0;
    always @(posedge sys_clk) sample_code <= temp_set;
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [15:0] sample_code;
    logic        alarm_output;
    logic [15:0] temp_set = 16'h0;
    logic [1:0]  rsp;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          tick = 0;
    int          dep [4] = '{1, 2, 4, 6};

    temp_alarm #(.CONV_CYCLES(20)) i_dut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .sample_code(sample_code),
        .alarm_output(alarm_output)
    );
    sensor_source i_src
    (
        .sys_clk(sys_clk), .temp_set(temp_set), .sample_code(sample_code)
    );

    always #5 sys_clk = ~sys_clk;
    // Ceiling well above the several hundred cycles the tests need
    always @(posedge sys_clk)
    begin
        cyc++;
        tick++;
        if (tick == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Bus, timing and check tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= 4'hf;
        avs_write <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Read data taken at the edge where waitrequest is seen low
    task rdt(input logic [3:0] a, input logic [31:0] exp);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rsp = avs_response;
        chk(avs_readdata, exp);
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task at(input int t);
        while (cyc < t) @(posedge sys_clk);
    endtask
    // Leaving shutdown restarts the conversion timer at a known cycle
    task restart(input logic [15:0] c);
        wr(4'h4, c | 16'h1);
        wr(4'h4, c);
        cyc = 0;
    endtask
    task settle;
        repeat (2) @(posedge sys_clk);
    endtask
    task give_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdt(4'h0, 32'h8000);
        rdt(4'h4, 32'h0);
        rdt(4'h8, 32'h4b00);
        rdt(4'hc, 32'h5000);
        chk(alarm_output, 1'b1);
        rdt(4'h1, 32'h0);
        chk(rsp, 2'h2);
        wr(4'h8, 16'h1900);
        wr(4'hc, 16'h3200);
        temp_set <= 16'h7d0f;
        restart(16'h08);
        rdt(4'h0, 32'h8000);
        at(30);
        chk(alarm_output, 1'b1);
        rdt(4'h0, 32'h7d00);
        at(50);
        chk(alarm_output, 1'b0);
        temp_set <= 16'h0;
        at(70);
        chk(alarm_output, 1'b0);
        at(90);
        chk(alarm_output, 1'b1);
        temp_set <= 16'h7d00;
        at(110);
        temp_set <= 16'h2000;
        at(130);
        temp_set <= 16'h7d00;
        at(150);
        chk(alarm_output, 1'b1);
        at(170);
        chk(alarm_output, 1'b0);
        wr(4'h8, 16'h1900);
        settle();
        chk(alarm_output, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            restart({11'h0, i[1:0], 3'h4});
            at(20 * dep[i] - 10);
            chk(alarm_output, 1'b0);
            at(20 * dep[i] + 10);
            chk(alarm_output, 1'b1);
        end
        restart(16'h02);
        at(30);
        chk(alarm_output, 1'b0);
        temp_set <= 16'h0;
        rdt(4'h0, 32'h7d00);
        settle();
        chk(alarm_output, 1'b1);
        at(50);
        chk(alarm_output, 1'b0);
        temp_set <= 16'h7d00;
        rdt(4'h4, 32'h2);
        settle();
        chk(alarm_output, 1'b1);
        at(70);
        chk(alarm_output, 1'b0);
        wr(4'hc, 16'h3200);
        settle();
        chk(alarm_output, 1'b1);
        at(90);
        chk(alarm_output, 1'b0);
        wr(4'h4, 16'h01);
        rdt(4'h0, 32'h8000);
        chk(alarm_output, 1'b1);
        at(cyc + 60);
        rdt(4'h0, 32'h8000);
        chk(alarm_output, 1'b1);
        give_verdict();
    end
endmodule

// File: tb/temp_alarm_props.sv
`timescale 1ns/100ps
module temp_alarm_props
#(
    parameter int unsigned CONV_CYCLES = 20
)
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic [15:0] sample_code,
    input wire logic        alarm_output
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_ok = avs_read && avs_address[1:0] == 2'h0;
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    no_wait_a: assert property (!avs_read |-> avs_waitrequest == 1'b0)
        else $error("waitrequest raised without a read");
    rd_wait_a: assert property (avs_read && avs_waitrequest
        |=> avs_waitrequest == 1'b0)
        else $error("read held off more than one cycle");
    resp_ok_a: assert property (rd_ok |=> avs_response == 2'h0)
        else $error("aligned read not ok");
    resp_err_a: assert property (avs_read && avs_address[1:0] != 2'h0
        |=> avs_response == 2'h2 && avs_readdata == 32'h0)
        else $error("unaligned read not refused");
    hold_rd_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    // ----------------------------------------
    // Register contents and alarm
    // ----------------------------------------
    temp_pad_a: assert property (rd_ok && avs_address[3:2] == 2'h0
        |=> avs_readdata[3:0] == 4'h0 && avs_readdata[31:16] == 16'h0)
        else $error("temperature padding not zero");
    cfg_pad_a: assert property (rd_ok && avs_address[3:2] == 2'h1
        |=> avs_readdata[31:5] == 27'h0)
        else $error("config upper bits not zero");
    lim_pad_a: assert property (rd_ok && avs_address[3]
        |=> avs_readdata[6:0] == 7'h0 && avs_readdata[31:16] == 16'h0)
        else $error("limit low bits not zero");
    cfg_clr_a: assert property (avs_write && avs_byteenable[0]
        && avs_address == 4'h4
        |=> ##1 alarm_output == !$past(avs_writedata[2], 2))
        else $error("config write left alarm active");
    cover property (rd_ok ##1 avs_readdata[15:0] == 16'h8000);
    cover property ($fell(alarm_output));
    cover property ($rose(alarm_output));
endmodule

bind temp_alarm temp_alarm_props #(.CONV_CYCLES(CONV_CYCLES)) i_props
(
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .sample_code(sample_code),
    .alarm_output(alarm_output)
);
